//--- hw/hub_cfg_defs.svh
// Offsets, field positions, reset values and limits of the hub power configuration bytes.
// Assumes inclusion by bare name from the configuration bank design module.
`ifndef HUB_CFG_DEFS_SVH
`define HUB_CFG_DEFS_SVH

// ==========================================================
// Byte offsets in the configuration image
`define CFG_OFS_PORT_OFF_SELFPOW   8'h09
`define CFG_OFS_PORT_OFF_BUSPOW    8'h0A
`define CFG_OFS_DRAW_SELFPOW       8'h0B
`define CFG_OFS_DRAW_BUSPOW        8'h0C

// ==========================================================
// Field layout
`define PORT_MASK_RSVD_BIT         0
`define PORT_MASK_RSVD_CLEAR       8'hFE

// ==========================================================
// Reset values
`define PORT_OFF_RESET             8'h00
`define DRAW_RESET                 8'h32
`define READ_UNMAPPED              8'h00

// ==========================================================
// Scaling and limits
`define DRAW_UNIT_MA               10'h002
`define DRAW_LIMIT_SELFPOW         8'h32

`endif

//--- hw/hub_cfg_pkg.sv
// Types shared by the hub power configuration modules.
// Assumes nothing beyond a SystemVerilog compiler.
package hub_cfg_pkg;

   // ==========================================================
   // Effective power mode
   typedef enum logic {
      MODE_BUS,
      MODE_SELF
   } power_mode_type;

endpackage

//--- hw/hub_port_disable_power_config.sv
// Port disable and upstream draw configuration bytes of a seven port hub.
// Assumes a loader on clk writing and reading bytes at image offsets.
`timescale 1ns/1ps
`include "hub_cfg_defs.svh"

module hub_port_disable_power_config
   import hub_cfg_pkg::*;
#(
   parameter int PORTS = 7
)
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             cfg_wr_en,
   input  wire logic             cfg_rd_en,
   input  wire logic [7:0]       cfg_addr,
   input  wire logic [7:0]       cfg_wr_data,
   output logic      [7:0]       cfg_rd_data,
   output logic                  cfg_rd_valid,
   input  wire logic             power_source_select,
   input  wire logic             dynamic_switch_en,
   input  wire logic             compound_cfg,
   input  wire logic             local_supply_sense_pin,
   output logic      [PORTS:0]   port_off,
   output logic      [7:0]       upstream_draw_units,
   output logic      [9:0]       upstream_draw_ma,
   output logic                  self_powered,
   output logic                  compound_device,
   output logic                  settings_switched,
   output logic                  port_mask_scattered,
   output logic                  selfpow_draw_over
);

   // ==========================================================
   // Helpers
   // Contiguous when adding the lowest set bit leaves no overlap
   function automatic logic mask_contiguous(input logic [7:0] m);
      logic [7:0] low;
      low = m & (~m + 8'h01);
      return ((m + low) & m) == 8'h00;
   endfunction

   function automatic logic [7:0] clear_rsvd(input logic [7:0] m);
      return m & `PORT_MASK_RSVD_CLEAR;
   endfunction

   // ==========================================================
   // Power mode selection
   power_mode_if pm ();

   power_mode_sel u_mode (
      .clk                    (clk),
      .rst                    (rst),
      .local_supply_sense_pin (local_supply_sense_pin),
      .power_source_select    (power_source_select),
      .dynamic_switch_en      (dynamic_switch_en),
      .pm                     (pm.producer)
   );

   // ==========================================================
   // Configuration bytes
   logic [7:0] port_off_mask_selfpow_q;
   logic [7:0] port_off_mask_buspow_q;
   logic [7:0] upstream_draw_selfpow_q;
   logic [7:0] upstream_draw_buspow_q;

   wire logic hit_off_self  = cfg_addr == `CFG_OFS_PORT_OFF_SELFPOW;
   wire logic hit_off_bus   = cfg_addr == `CFG_OFS_PORT_OFF_BUSPOW;
   wire logic hit_draw_self = cfg_addr == `CFG_OFS_DRAW_SELFPOW;
   wire logic hit_draw_bus  = cfg_addr == `CFG_OFS_DRAW_BUSPOW;

   // Reserved bit dropped on the way in so it can never be stored
   wire logic [7:0] wr_mask = clear_rsvd(cfg_wr_data);

   always_ff @(posedge clk) begin
      if (rst) begin
         port_off_mask_selfpow_q <= `PORT_OFF_RESET;
         port_off_mask_buspow_q  <= `PORT_OFF_RESET;
         upstream_draw_selfpow_q <= `DRAW_RESET;
         upstream_draw_buspow_q  <= `DRAW_RESET;
      end else if (cfg_wr_en) begin
         if (hit_off_self) begin
            port_off_mask_selfpow_q <= wr_mask;
         end
         if (hit_off_bus) begin
            port_off_mask_buspow_q <= wr_mask;
         end
         if (hit_draw_self) begin
            upstream_draw_selfpow_q <= cfg_wr_data;
         end
         if (hit_draw_bus) begin
            upstream_draw_buspow_q <= cfg_wr_data;
         end
      end
   end

   // ==========================================================
   // Read back
   logic [7:0] rd_data_q;
   logic       rd_valid_q;
   logic [7:0] rd_sel;

   assign rd_sel = hit_off_self  ? port_off_mask_selfpow_q :
                   hit_off_bus   ? port_off_mask_buspow_q  :
                   hit_draw_self ? upstream_draw_selfpow_q :
                   hit_draw_bus  ? upstream_draw_buspow_q  :
                                   `READ_UNMAPPED;

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data_q  <= 8'h00;
         rd_valid_q <= 1'b0;
      end else begin
         rd_data_q  <= cfg_rd_en ? rd_sel : rd_data_q;
         rd_valid_q <= cfg_rd_en;
      end
   end

   assign cfg_rd_data  = rd_data_q;
   assign cfg_rd_valid = rd_valid_q;

   // ==========================================================
   // Active settings for the effective mode
   // Selection follows the registered mode every cycle, so a mode
   // change or a new byte shows one cycle later with no stale copy
   wire logic       mode_self   = pm.mode == MODE_SELF;
   wire logic [7:0] active_mask = mode_self ? port_off_mask_selfpow_q
                                            : port_off_mask_buspow_q;
   wire logic [7:0] active_draw = mode_self ? upstream_draw_selfpow_q
                                            : upstream_draw_buspow_q;
   // Count of 2 mA units scaled to mA, so fifty reads as 100
   wire logic [9:0] active_ma   = 10'(active_draw) * `DRAW_UNIT_MA;

   logic [PORTS:0] port_off_q;
   logic [7:0]     draw_units_q;
   logic [9:0]     draw_ma_q;
   logic           self_q;
   logic           compound_q;
   logic           switched_q;
   logic           scattered_q;
   logic           draw_over_q;

   // One flop per port, each its own variable so no bit has two writers
   genvar p;
   generate
      for (p = 1; p <= PORTS; p++) begin : g_port
         logic off_q;
         always_ff @(posedge clk) begin
            if (rst) begin
               off_q <= 1'b0;
            end else begin
               off_q <= active_mask[p];
            end
         end
         assign port_off_q[p] = off_q;
      end
   endgenerate

   // Reserved bit kept as a flop so every output bit is registered
   logic rsvd_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         rsvd_q <= 1'b0;
      end else begin
         rsvd_q <= 1'b0;
      end
   end

   assign port_off_q[`PORT_MASK_RSVD_BIT] = rsvd_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         draw_units_q <= `DRAW_RESET;
         draw_ma_q    <= 10'h000;
         self_q       <= 1'b0;
         compound_q   <= 1'b0;
         switched_q   <= 1'b0;
      end else begin
         draw_units_q <= active_draw;
         draw_ma_q    <= active_ma;
         self_q       <= mode_self;
         compound_q   <= compound_cfg;
         switched_q   <= pm.mode_changed;
      end
   end

   // ==========================================================
   // Loader sanity flags
   // Only reported; the hub still applies what was loaded
   always_ff @(posedge clk) begin
      if (rst) begin
         scattered_q <= 1'b0;
         draw_over_q <= 1'b0;
      end else begin
         scattered_q <= ~mask_contiguous(port_off_mask_selfpow_q) |
                        ~mask_contiguous(port_off_mask_buspow_q);
         draw_over_q <= upstream_draw_selfpow_q > `DRAW_LIMIT_SELFPOW;
      end
   end

   // ==========================================================
   // Outputs
   assign port_off            = port_off_q;
   assign upstream_draw_units = draw_units_q;
   assign upstream_draw_ma    = draw_ma_q;
   assign self_powered        = self_q;
   assign compound_device     = compound_q;
   assign settings_switched   = switched_q;
   assign port_mask_scattered = scattered_q;
   assign selfpow_draw_over   = draw_over_q;

endmodule

//--- hw/power_mode_if.sv
// Carrier for the effective power mode between selector and register bank.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface power_mode_if;
   import hub_cfg_pkg::*;

   power_mode_type mode;
   logic           mode_changed;

   modport producer (output mode, output mode_changed);
   modport consumer (input mode, input mode_changed);
endinterface

//--- hw/power_mode_sel.sv
// Effective power mode selection from the configured source or the sense pin.
// Assumes the sense pin is asynchronous to clk; config inputs are on clk.
`timescale 1ns/1ps

module power_mode_sel
   import hub_cfg_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        local_supply_sense_pin,
   input  wire logic        power_source_select,
   input  wire logic        dynamic_switch_en,
   power_mode_if.producer   pm
);

   // ==========================================================
   // Pin synchroniser
   logic           sense_meta_q;
   logic           sense_sync_q;
   power_mode_type mode_q;
   power_mode_type mode_d;
   logic           changed_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         sense_meta_q <= 1'b0;
         sense_sync_q <= 1'b0;
      end else begin
         sense_meta_q <= local_supply_sense_pin;
         sense_sync_q <= sense_meta_q;
      end
   end

   // ==========================================================
   // Mode selection
   wire logic self_src = dynamic_switch_en ? sense_sync_q : power_source_select;

   assign mode_d = self_src ? MODE_SELF : MODE_BUS;

   always_ff @(posedge clk) begin
      if (rst) begin
         mode_q    <= MODE_BUS;
         changed_q <= 1'b0;
      end else begin
         mode_q    <= mode_d;
         changed_q <= (mode_d != mode_q);
      end
   end

   assign pm.mode         = mode_q;
   assign pm.mode_changed = changed_q;

endmodule

//--- tb/hub_cfg_loader.sv
// Configuration loader model driving the byte port of the bank.
// Assumes the caller owns sequencing; one byte per call.
`timescale 1ns/1ps

module hub_cfg_loader (
   input  wire logic       clk,
   output logic            wr_en,
   output logic            rd_en,
   output logic [7:0]      addr,
   output logic [7:0]      wr_data,
   input  wire logic [7:0] rd_data,
   input  wire logic       rd_valid
);
   initial begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 8'hFF;
      wr_data = 8'hFF;
   end

   // ==========================================================
   // Byte access
   // Data turns to its inverse once released, so a stale byte never matches
   task automatic put_byte(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      addr <= a;
      wr_data <= d;
      @(posedge clk);
      wr_en <= 1'b0;
      wr_data <= ~d;
   endtask

   task automatic get_byte(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      v = rd_valid;
      d = rd_data;
   endtask
endmodule

//--- tb/hub_port_disable_power_config_properties.sv
// Concurrent checks on the ports of the hub power configuration bank.
// Assumes one clk domain and a synchronous active-high rst.
`timescale 1ns/1ps

module hub_cfg_checker #(
   parameter int PORTS = 7
)
(
   input wire logic             clk,
   input wire logic             rst,
   input wire logic             cfg_wr_en,
   input wire logic             cfg_rd_en,
   input wire logic             cfg_rd_valid,
   input wire logic             power_source_select,
   input wire logic             dynamic_switch_en,
   input wire logic             compound_cfg,
   input wire logic             local_supply_sense_pin,
   input wire logic [PORTS:0]   port_off,
   input wire logic [7:0]       upstream_draw_units,
   input wire logic [9:0]       upstream_draw_ma,
   input wire logic             self_powered,
   input wire logic             compound_device,
   input wire logic             settings_switched
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // ==========================================================
   // Mode sequences
   // Pin path is two flops deeper, so it needs a longer steady run
   sequence cfg_self_s;
      (!dynamic_switch_en && power_source_select)[*3];
   endsequence
   sequence cfg_bus_s;
      (!dynamic_switch_en && !power_source_select)[*3];
   endsequence
   sequence pin_self_s;
      (dynamic_switch_en && local_supply_sense_pin)[*5];
   endsequence

   // ==========================================================
   // Properties
   chk_read_valid_timing: assert property (cfg_rd_valid == $past(cfg_rd_en))
      else $error("read valid not one cycle after read strobe");
   chk_rsvd_bit_zero: assert property (port_off[0] == 1'b0)
      else $error("reserved port bit set");
   chk_draw_in_ma: assert property ($stable(upstream_draw_units) && !$past(rst)
      |-> upstream_draw_ma == {1'b0, upstream_draw_units, 1'b0})
      else $error("draw in mA not twice the unit count");
   chk_switch_on_change: assert property
      (settings_switched == (self_powered != $past(self_powered)))
      else $error("switch pulse not aligned with mode change");
   chk_cfg_self_mode: assert property (cfg_self_s |-> self_powered)
      else $error("config bit self not applied");
   chk_cfg_bus_mode: assert property (cfg_bus_s |-> !self_powered)
      else $error("config bit bus not applied");
   chk_pin_self_mode: assert property (pin_self_s |-> self_powered)
      else $error("sense pin not applied");
   chk_mask_quiet: assert property
      (!cfg_wr_en ##2 $stable(self_powered) |-> $stable(port_off))
      else $error("port mask moved without write or mode change");
   chk_compound_copy: assert property (compound_cfg[*2] |-> compound_device)
      else $error("compound flag not followed");
endmodule

bind hub_port_disable_power_config hub_cfg_checker #(.PORTS(PORTS)) chk (
   .clk(clk), .rst(rst), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
   .cfg_rd_valid(cfg_rd_valid), .power_source_select(power_source_select),
   .dynamic_switch_en(dynamic_switch_en), .compound_cfg(compound_cfg),
   .local_supply_sense_pin(local_supply_sense_pin), .port_off(port_off),
   .upstream_draw_units(upstream_draw_units), .upstream_draw_ma(upstream_draw_ma),
   .self_powered(self_powered), .compound_device(compound_device),
   .settings_switched(settings_switched));

//--- tb/hub_port_disable_power_config_tb_top.sv
// Self-checking bench for the hub power configuration bank.
// Assumes the loader model and the bound checker are compiled alongside.
`timescale 1ns/1ps

module hub_port_disable_power_config_tb_top;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       psel = 1'b0;
   logic       dyn = 1'b0;
   logic       cmpd = 1'b0;
   logic       pin = 1'b0;
   logic       wr_en, rd_en, rd_valid, self_pw, cmp_dev, scat, over;
   logic [7:0] addr, wr_data, rd_data, port_off, units;
   logic [9:0] draw_ma;
   int         mismatches = 0;
   int         total_checks = 0;

   always #50 clk = ~clk;

   hub_port_disable_power_config #(.PORTS(7)) DUT (
      .clk(clk), .rst(rst), .cfg_wr_en(wr_en), .cfg_rd_en(rd_en), .cfg_addr(addr),
      .cfg_wr_data(wr_data), .cfg_rd_data(rd_data), .cfg_rd_valid(rd_valid),
      .power_source_select(psel), .dynamic_switch_en(dyn), .compound_cfg(cmpd),
      .local_supply_sense_pin(pin), .port_off(port_off), .upstream_draw_units(units),
      .upstream_draw_ma(draw_ma), .self_powered(self_pw), .compound_device(cmp_dev),
      .settings_switched(), .port_mask_scattered(scat), .selfpow_draw_over(over));

   hub_cfg_loader LDR (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
      .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid));

   // ==========================================================
   // Helpers
   task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Pin path is the slowest at four edges; six covers it with margin
   task automatic settle;
      repeat (6) @(posedge clk);
      #1;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic       v;
      LDR.get_byte(a, d, v);
      check("rd_valid", {9'h0, v}, 10'h001);
      check("rd_data", {2'h0, d}, {2'h0, exp});
   endtask

   // ==========================================================
   // Tests
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd_chk(8'h09, 8'h00);
      rd_chk(8'h0B, 8'h32);
      rd_chk(8'h0D, 8'h00);
      LDR.put_byte(8'h09, 8'h0F);
      LDR.put_byte(8'h0A, 8'h06);
      LDR.put_byte(8'h0B, 8'h19);
      LDR.put_byte(8'h0C, 8'hFA);
      rd_chk(8'h09, 8'h0E);
      rd_chk(8'h0C, 8'hFA);
      settle;
      check("port_off", {2'h0, port_off}, 10'h006);
      check("draw_ma", draw_ma, 10'h1F4);
      check("compound", {9'h0, cmp_dev}, 10'h000);
      psel <= 1'b1;
      settle;
      check("self_powered", {9'h0, self_pw}, 10'h001);
      check("port_off", {2'h0, port_off}, 10'h00E);
      check("draw_ma", draw_ma, 10'h032);
      for (int n = 1; n <= 7; n++) begin
         LDR.put_byte(8'h09, 8'h01 << n);
         settle;
         check("port_off", {2'h0, port_off}, {2'h0, 8'h01 << n});
      end
      LDR.put_byte(8'h0B, 8'h32);
      settle;
      check("draw_ma", draw_ma, 10'h064);
      check("draw_units", {2'h0, units}, 10'h032);
      dyn <= 1'b1;
      settle;
      check("self_powered", {9'h0, self_pw}, 10'h000);
      check("port_off", {2'h0, port_off}, 10'h006);
      pin <= 1'b1;
      psel <= 1'b0;
      settle;
      check("self_powered", {9'h0, self_pw}, 10'h001);
      cmpd <= 1'b1;
      settle;
      check("compound", {9'h0, cmp_dev}, 10'h001);
      check("scattered", {9'h0, scat}, 10'h000);
      check("draw_over", {9'h0, over}, 10'h000);
      // Deliberate loader faults: flags report, the hub still applies them
      LDR.put_byte(8'h0A, 8'h12);
      LDR.put_byte(8'h0B, 8'h33);
      settle;
      check("scattered", {9'h0, scat}, 10'h001);
      check("draw_over", {9'h0, over}, 10'h001);
      dyn <= 1'b0;
      settle;
      check("self_powered", {9'h0, self_pw}, 10'h000);
      check("port_off", {2'h0, port_off}, 10'h012);
      wrap_up;
   end

   // Whole sequence needs about 135 cycles
   initial begin
      repeat (3000) @(posedge clk);
      mismatches++;
      wrap_up;
   end
endmodule
